// ==== core/mtc_pkg.sv ====
// Purpose: constants shared by the multimode timer channel
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes: offsets are byte addresses
package mtc_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;
  // register byte offsets
  localparam logic [7:0] OFS_TIMER = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  // control field positions
  localparam int CB_START = 0;
  localparam int CB_MODE = 1;
  localparam int CB_CLK_LO = 2;
  localparam int CB_GATE_EN = 4;
  localparam int CB_GATE_LVL = 5;
  localparam int CB_PULSE = 6;
  localparam int CB_EDGE = 7;
  localparam int CB_SRC = 8;
  localparam int CB_DIR_EXT = 9;
  localparam int CB_DIR_UP = 10;
  localparam int CB_FREE = 11;
  localparam int CTRL_W = 12;
  localparam logic [11:0] CTRL_RST = 12'h000;
  // status field positions
  localparam int SB_OUT = 0;
  localparam int SB_RUN = 1;
  localparam int SB_TWO_PH = 2;
  // prescaler tap widths: f8 and f32, and fc32 from the sub clock
  localparam int PRE_W = 5;
  localparam logic [4:0] PRE_RST = 5'h00;
  localparam logic [4:0] DIV8_MASK = 5'h07;
  localparam logic [4:0] DIV32_MASK = 5'h1F;
  // count source codes
  typedef enum logic [1:0] {
    MTC_SRC_F1 = 2'h0,
    MTC_SRC_F8 = 2'h1,
    MTC_SRC_F32 = 2'h2,
    MTC_SRC_FC32 = 2'h3
  } mtc_clk_t;
endpackage : mtc_pkg

// ==== core/mtc_timer.sv ====
// Purpose: one 16-bit timer channel with timer and event counter modes
// Assumes: 100 MHz hclk, AHB-Lite slave, zero wait states
// Notes: two-phase counting is not built in this block
// What this block does
// - timer mode counts f1, f8, f32 or fc32 chosen by software.
// - timer mode counts down and reloads from reload on underflow.
// - down counting from n divides the source by n plus one.
// - up counting from n divides events by FFFF minus n plus one.
// - counting only while the start flag is 1, halted at 0.
// - timer mode raises an interrupt request on every underflow.
// - with gate on, input pin level allows or suspends timer counting.
// - timer mode pulse output toggles the output pin on each underflow.
// - writing while stopped loads both reload register and counter.
// - writing while counting loads reload only; counter takes it at reload.
// - reading the timer register returns the current counter.
// - event mode counts chosen input pin edges or neighbour overflows.
// - event direction comes from software or the output pin as input.
// - event mode reloads on overflow or underflow unless free-run.
// - event mode raises an interrupt request on overflow or underflow.
// - free-run keeps counting from the wrapped value without reload.
// - event mode pulse output toggles the output pin on each wrap.
// - output pin is port, pulse output or direction input in event mode.
// - every channel counts single-phase only; status flags two-phase for CHANNEL 2 and up.
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module mtc_timer #(
  parameter int CHANNEL = 0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins and neighbour
  input wire logic timer_input_pin,
  input wire logic timer_output_pin_i,
  output logic timer_output_pin_o,
  output logic timer_output_pin_oe,
  input wire logic sub_clk_pin,
  input wire logic neighbour_timer_channel_ovf,
  // events
  output logic irq_req,
  output logic wrap_pulse
);
  import mtc_pkg::*;

  function automatic logic sync_filt(input logic s2, input logic s3, input logic q);
    sync_filt = (s2 == s3) ? s3 : q;
  endfunction : sync_filt

  // bus address phase capture
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  wire addr_ok = hsel && htrans[1] && hready;
  wire [7:0] a_ofs = haddr[7:0];

  // control and counter state
  logic [CTRL_W-1:0] ctrl_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] rld_reg;
  logic out_reg;
  logic irq_reg;

  wire start = ctrl_reg[CB_START];
  wire evt_mode = ctrl_reg[CB_MODE];
  wire [1:0] clk_sel = ctrl_reg[CB_CLK_LO+1:CB_CLK_LO];
  wire gate_en = ctrl_reg[CB_GATE_EN];
  wire gate_lvl = ctrl_reg[CB_GATE_LVL];
  wire pulse_en = ctrl_reg[CB_PULSE];
  wire edge_rise = ctrl_reg[CB_EDGE];
  wire src_nb = ctrl_reg[CB_SRC];
  wire dir_ext = ctrl_reg[CB_DIR_EXT];
  wire dir_sw_up = ctrl_reg[CB_DIR_UP];
  wire free_run = ctrl_reg[CB_FREE];

  // pin synchronisers
  logic [2:0] in_sync_reg;
  logic [2:0] dir_sync_reg;
  logic [2:0] sub_sync_reg;
  logic in_filt_reg;
  logic in_prev_reg;
  logic dir_filt_reg;
  logic sub_filt_reg;
  logic sub_prev_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_sync_reg <= 3'h0;
      dir_sync_reg <= 3'h0;
      sub_sync_reg <= 3'h0;
      in_filt_reg <= 1'b0;
      in_prev_reg <= 1'b0;
      dir_filt_reg <= 1'b0;
      sub_filt_reg <= 1'b0;
      sub_prev_reg <= 1'b0;
    end else begin
      in_sync_reg <= {in_sync_reg[1:0], timer_input_pin};
      dir_sync_reg <= {dir_sync_reg[1:0], timer_output_pin_i};
      sub_sync_reg <= {sub_sync_reg[1:0], sub_clk_pin};
      in_filt_reg <= sync_filt(in_sync_reg[1], in_sync_reg[2], in_filt_reg);
      in_prev_reg <= in_filt_reg;
      dir_filt_reg <= sync_filt(dir_sync_reg[1], dir_sync_reg[2], dir_filt_reg);
      sub_filt_reg <= sync_filt(sub_sync_reg[1], sub_sync_reg[2], sub_filt_reg);
      sub_prev_reg <= sub_filt_reg;
    end
  end

  // prescaler taps
  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_sub_reg;
  wire sub_rise = sub_filt_reg && !sub_prev_reg;
  wire tap_f8 = (pre_reg & DIV8_MASK) == DIV8_MASK;
  wire tap_f32 = (pre_reg & DIV32_MASK) == DIV32_MASK;
  wire tap_fc32 = sub_rise && (pre_sub_reg == DIV32_MASK);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg <= PRE_RST;
      pre_sub_reg <= PRE_RST;
    end else begin
      pre_reg <= pre_reg + 5'h01;
      if (sub_rise) begin
        pre_sub_reg <= pre_sub_reg + 5'h01;
      end
    end
  end

  // count source selection
  logic tap_sel;
  always_comb begin
    case (mtc_clk_t'(clk_sel))
      MTC_SRC_F1: tap_sel = 1'b1;
      MTC_SRC_F8: tap_sel = tap_f8;
      MTC_SRC_F32: tap_sel = tap_f32;
      MTC_SRC_FC32: tap_sel = tap_fc32;
      default: tap_sel = 1'b0;
    endcase
  end

  wire gate_ok = !gate_en || (in_filt_reg == gate_lvl);
  wire pin_edge = edge_rise ? (in_filt_reg && !in_prev_reg)
                            : (!in_filt_reg && in_prev_reg);
  wire evt_src = src_nb ? neighbour_timer_channel_ovf : pin_edge;
  wire count_up = evt_mode && (dir_ext ? dir_filt_reg : dir_sw_up);
  wire tick = start && (evt_mode ? evt_src : (tap_sel && gate_ok));
  wire at_max = cnt_reg == CNT_MAX;
  wire at_zero = cnt_reg == CNT_RST;
  wire wrap = tick && (count_up ? at_max : at_zero);
  wire reload_now = wrap && !(evt_mode && free_run);

  // bus write decode
  wire wr_timer = wr_pend_reg && (wr_addr_reg == OFS_TIMER);
  wire wr_ctrl = wr_pend_reg && (wr_addr_reg == OFS_CTRL);
  wire [CNT_W-1:0] wr_val = hwdata[CNT_W-1:0];

  always_comb begin
    cnt_next = cnt_reg;
    if (tick) begin
      if (reload_now) begin
        cnt_next = rld_reg;
      end else if (count_up) begin
        cnt_next = cnt_reg + 16'h0001;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end
    if (wr_timer && !start) begin
      cnt_next = wr_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= CNT_RST;
      rld_reg <= CNT_RST;
      ctrl_reg <= CTRL_RST;
      out_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (wr_timer) begin
        rld_reg <= wr_val;
      end
      if (wr_ctrl) begin
        ctrl_reg <= hwdata[CTRL_W-1:0];
      end
      if (wrap && pulse_en) begin
        out_reg <= !out_reg;
      end
      irq_reg <= wrap;
    end
  end

  // bus read data, registered into the data phase
  logic [31:0] rd_mux;
  always_comb begin
    case (a_ofs)
      OFS_TIMER: rd_mux = {16'h0000, cnt_reg};
      OFS_CTRL: rd_mux = {20'h0_0000, ctrl_reg};
      OFS_STAT: rd_mux = {29'h0000_0000, (CHANNEL >= 2), start, out_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_reg <= a_ofs;
      end
      if (addr_ok && !hwrite) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq_req = irq_reg;
  assign wrap_pulse = irq_reg;
  assign timer_output_pin_o = out_reg;
  // drive only as pulse output; direction input or port otherwise
  assign timer_output_pin_oe = pulse_en && !(evt_mode && dir_ext);

  // helper counters for tap spacing
  logic [PRE_W-1:0] f8_gap_reg;
  logic [PRE_W-1:0] f32_gap_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f8_gap_reg <= PRE_RST;
      f32_gap_reg <= PRE_RST;
    end else begin
      f8_gap_reg <= tap_f8 ? PRE_RST : f8_gap_reg + 5'h01;
      f32_gap_reg <= tap_f32 ? PRE_RST : f32_gap_reg + 5'h01;
    end
  end

  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_TIMER_SRC_F8: assert property (
    (!evt_mode && start && !gate_en && clk_sel == 2'h1 && !wr_timer && !tap_f8)
      |=> $stable(cnt_reg))
    else $error("f8 source counted off its tap");
  AST_UNDERFLOW_RELOAD: assert property (
    (tick && !evt_mode && at_zero && !wr_timer) |=> cnt_reg == $past(rld_reg))
    else $error("underflow did not reload");
  AST_DOWN_STEP: assert property (
    (tick && !count_up && !at_zero) |=> cnt_reg == $past(cnt_reg) - 16'h0001)
    else $error("down count step wrong");
  AST_UP_WRAP: assert property (
    (tick && count_up && at_max && !free_run) |=> cnt_reg == $past(rld_reg))
    else $error("overflow did not reload");
  AST_STOP_HOLD: assert property (
    (!start && !wr_timer) |=> $stable(cnt_reg))
    else $error("counter moved while stopped");
  AST_IRQ_ON_WRAP: assert property (
    wrap |=> irq_req)
    else $error("interrupt request not raised on wrap");
  AST_IRQ_QUIET: assert property (
    !wrap |=> !irq_req)
    else $error("interrupt request without a wrap");
  AST_GATE_HOLD: assert property (
    (!evt_mode && gate_en && in_filt_reg != gate_lvl && !wr_timer) |=> $stable(cnt_reg))
    else $error("gate did not suspend counting");
  AST_PULSE_TOGGLE: assert property (
    (wrap && pulse_en) |=> timer_output_pin_o != $past(timer_output_pin_o))
    else $error("output pin did not toggle");
  AST_WRITE_STOPPED: assert property (
    (wr_timer && !start) |=> cnt_reg == $past(wr_val) && rld_reg == $past(wr_val))
    else $error("stopped write not loaded in both");
  AST_WRITE_RUNNING: assert property (
    (wr_timer && start && !tick) |=> cnt_reg == $past(cnt_reg))
    else $error("running write touched counter");
  AST_FREE_RUN: assert property (
    (tick && evt_mode && free_run && count_up && at_max) |=> cnt_reg == CNT_RST)
    else $error("free-run did not wrap");
  AST_FREE_RUN_DOWN: assert property (
    (tick && evt_mode && free_run && !count_up && at_zero) |=> cnt_reg == CNT_MAX)
    else $error("free-run did not wrap below zero");
  AST_TIMER_SRC_F1: assert property (
    (!evt_mode && start && !gate_en && clk_sel == 2'h0)
      |=> cnt_reg == ($past(at_zero) ? $past(rld_reg) : $past(cnt_reg) - 16'h0001))
    else $error("f1 source missed a count");
  AST_TIMER_SRC_F32: assert property (
    (!evt_mode && start && !gate_en && clk_sel == 2'h2 && !wr_timer && !tap_f32)
      |=> $stable(cnt_reg))
    else $error("f32 source counted off its tap");
  AST_TIMER_SRC_FC32: assert property (
    (!evt_mode && start && !gate_en && clk_sel == 2'h3 && !wr_timer && !tap_fc32)
      |=> $stable(cnt_reg))
    else $error("fc32 source counted off its tap");
  AST_F8_SPACING: assert property (
    tap_f8 |-> f8_gap_reg == DIV8_MASK)
    else $error("f8 tap spacing wrong");
  AST_F32_SPACING: assert property (
    tap_f32 |-> f32_gap_reg == DIV32_MASK)
    else $error("f32 tap spacing wrong");
  AST_TIMER_DOWN_ONLY: assert property (
    !evt_mode |-> !count_up)
    else $error("timer mode counting up");
  AST_EVT_UP_STEP: assert property (
    (tick && count_up && !at_max) |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("up count step wrong");
  AST_EVT_DOWN_RELOAD: assert property (
    (tick && evt_mode && !count_up && at_zero && !free_run) |=> cnt_reg == $past(rld_reg))
    else $error("event underflow did not reload");
  AST_GATE_PASS: assert property (
    (!evt_mode && start && gate_en && in_filt_reg == gate_lvl && clk_sel == 2'h0)
      |=> cnt_reg == ($past(at_zero) ? $past(rld_reg) : $past(cnt_reg) - 16'h0001))
    else $error("open gate did not count");
  AST_PULSE_HOLD: assert property (
    !(wrap && pulse_en) |=> $stable(timer_output_pin_o))
    else $error("output pin moved without a wrap");
  AST_RELOAD_HOLD: assert property (
    !wr_timer |=> $stable(rld_reg))
    else $error("reload register moved without a write");
  AST_WRITE_RUNNING_RLD: assert property (
    (wr_timer && start) |=> rld_reg == $past(wr_val))
    else $error("running write missed the reload register");
  AST_READ_TIMER: assert property (
    (addr_ok && !hwrite && a_ofs == OFS_TIMER)
      |=> hrdata == {16'h0000, $past(cnt_reg)})
    else $error("timer read not the counter value");
  AST_EVT_PIN_ONLY: assert property (
    (start && evt_mode && !src_nb && !pin_edge && !wr_timer)
      |=> $stable(cnt_reg))
    else $error("event count without a pin edge");
  AST_EVT_NB_ONLY: assert property (
    (start && evt_mode && src_nb && !neighbour_timer_channel_ovf && !wr_timer)
      |=> $stable(cnt_reg))
    else $error("event count without a neighbour overflow");
  AST_DIR_EXT_UP: assert property (
    (tick && evt_mode && dir_ext && dir_filt_reg && !at_max)
      |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("external direction up not followed");
  AST_DIR_SW_DOWN: assert property (
    (tick && evt_mode && !dir_ext && !dir_sw_up && !at_zero)
      |=> cnt_reg == $past(cnt_reg) - 16'h0001)
    else $error("software direction down not followed");
  AST_EVT_IRQ: assert property (
    (tick && evt_mode && !count_up && at_zero) |=> irq_req && wrap_pulse)
    else $error("event underflow raised no request");
  AST_EVT_PULSE: assert property (
    (tick && evt_mode && pulse_en && count_up && at_max)
      |=> timer_output_pin_o != $past(timer_output_pin_o))
    else $error("output pin did not toggle on overflow");
  AST_OE_DIR_IN: assert property (
    (evt_mode && dir_ext) |-> !timer_output_pin_oe)
    else $error("output pin driven while used as direction input");
  AST_OE_PULSE: assert property (
    (pulse_en && !(evt_mode && dir_ext)) |-> timer_output_pin_oe)
    else $error("pulse output not driven");
  AST_STAT_TWO_PHASE: assert property (
    (addr_ok && !hwrite && a_ofs == OFS_STAT)
      |=> hrdata[SB_TWO_PH] == (CHANNEL >= 2))
    else $error("two-phase status bit wrong");
  AST_READ_UPPER: assert property (
    (addr_ok && !hwrite && a_ofs == OFS_TIMER)
      |=> hrdata[31:16] == 16'h0000)
    else $error("timer read upper half not zero");
  AST_SYNC_AGREE: assert property (
    $changed(in_filt_reg) |-> in_filt_reg == in_sync_reg[2])
    else $error("input pin change passed unsynchronised");
endmodule : mtc_timer

// ==== verif/mtc_pin_model.sv ====
// Purpose: far-side model of the channel input pin
// Assumes: levels change just after a rising clock edge
// Notes: each level is held long enough to pass the synchroniser
`timescale 1ns/1ps
module mtc_pin_model (
  // clock
  input wire logic hclk,
  // pin
  output logic pin
);
  initial pin = 1'b0;
  // one full pulse per event, 8 clocks high, then 9 low before the next
  task pulse(input int k);
    repeat (k) begin
      @(posedge hclk);
      pin <= 1'b1;
      repeat (8) @(posedge hclk);
      pin <= 1'b0;
      repeat (8) @(posedge hclk);
    end
  endtask : pulse
  // steady gate level
  task hold(input logic v);
    @(posedge hclk);
    pin <= v;
  endtask : hold
endmodule : mtc_pin_model

// ==== verif/mtc_timer_tb.sv ====
// Purpose: self-checking bench for the timer channel
// Assumes: one ahb-lite slave, hready taken from hreadyout
// Notes: expected counts come from an integer model
`timescale 1ns/1ps
module mtc_timer_tb;
  import mtc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0] hsize = 3'h2;
  logic [2:0] sdiv = 3'h0;
  logic [31:0] hrdata, rv, sv;
  logic hreadyout, hresp, tin, pin_i, pin_o, pin_oe, irq_req, wp, p, up;
  logic nb = 1'b0;
  logic dir = 1'b0;
  int n_mismatch = 0;
  int checks = 0;
  int seed = 7077;
  int nirq = 0;
  int nwp = 0;
  int c, n, m, k, e, w, w2, q;
  int cn[8] = '{-1, 32'h0000_FFFE, 32'h0000_FFFF, 0, -1, -1, -1, -1};
  logic [11:0] cx[8] = '{12'h0c0, 12'h4c0, 12'hcc0, 12'h8c0, 12'h280, 12'h2c0, 12'h140, 12'h040};
  always #5 hclk = ~hclk;
  always @(posedge hclk) if (irq_req === 1'b1) nirq <= nirq + 1;
  always @(posedge hclk) if (wp === 1'b1) nwp <= nwp + 1;
  always @(posedge hclk) sdiv <= sdiv + 3'h1;
  assign pin_i = pin_oe ? pin_o : dir;
  mtc_timer #(.CHANNEL(2)) u_mtc_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_input_pin(tin), .timer_output_pin_i(pin_i), .timer_output_pin_o(pin_o),
    .timer_output_pin_oe(pin_oe), .sub_clk_pin(sdiv[2]), .neighbour_timer_channel_ovf(nb),
    .irq_req(irq_req), .wrap_pulse(wp));
  mtc_pin_model u_mtc_pin_model (.hclk(hclk), .pin(tin));
  task test_done;
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, s, x);
    end
  endtask : chk
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    repeat (2) begin
      i = 0;
      do begin
        @(posedge hclk);
        i++;
      end while (hreadyout !== 1'b1 && i < 64);
      if (i >= 64) begin
        n_mismatch++;
        test_done;
      end
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
    end
    rv = hrdata;
    chk(hresp, 32'h0000_0000);
  endtask : ahb
  task irqw;
    c = 0;
    do begin
      @(negedge hclk);
      c++;
    end while (irq_req !== 1'b1 && c < 4000);
    if (c >= 4000) begin
      n_mismatch++;
      test_done;
    end
  endtask : irqw
  task per;
    irqw;
    p = pin_o;
    irqw;
    chk(pin_o, !p);
  endtask : per
  task pulse_nb(input int k);
    repeat (k) begin
      @(posedge hclk);
      nb <= 1'b1;
      @(posedge hclk);
      nb <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask : pulse_nb
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (q = 0; q < 4; q++) begin
      ahb(1'b0, 8'(q * 4), 32'h0000_0000);
      chk(rv, (q == 2) ? 32'h0000_0004 : 32'h0000_0000);
    end
    for (q = 0; q < 4; q++) begin
      e = (q == 0) ? 1 : (q == 1) ? 8 : (q == 2) ? 32 : 256;
      n = $random(seed) & 3;
      ahb(1'b1, OFS_CTRL, 32'h0000_0000);
      ahb(1'b1, OFS_TIMER, n);
      ahb(1'b0, OFS_TIMER, 32'h0000_0000);
      chk(rv, n);
      ahb(1'b1, OFS_CTRL, 32'h0000_0041 | (q << 2));
      per;
      chk(c, (n + 1) * e);
      m = n + 4;
      if (q >= 2) irqw;
      ahb(1'b1, OFS_TIMER, m);
      ahb(1'b0, OFS_TIMER, 32'h0000_0000);
      if (q >= 2) chk(rv <= n, 1);
      per;
      chk(c, (m + 1) * e);
    end
    ahb(1'b1, OFS_CTRL, 32'h0000_0000);
    ahb(1'b0, OFS_TIMER, 32'h0000_0000);
    sv = rv;
    repeat (40) @(posedge hclk);
    ahb(1'b0, OFS_TIMER, 32'h0000_0000);
    chk(rv, sv);
    ahb(1'b0, OFS_STAT, 32'h0000_0000);
    chk(rv & 32'h0000_0006, 32'h0000_0004);
    u_mtc_pin_model.hold(1'b0);
    ahb(1'b1, OFS_TIMER, 32'h0000_0005);
    ahb(1'b1, OFS_CTRL, 32'h0000_0071);
    repeat (20) @(posedge hclk);
    ahb(1'b0, OFS_TIMER, 32'h0000_0000);
    chk(rv, 32'h0000_0005);
    u_mtc_pin_model.hold(1'b1);
    per;
    chk(c, 6);
    u_mtc_pin_model.hold(1'b0);
    for (q = 0; q < 8; q++) begin
      n = (cn[q] < 0) ? ($random(seed) & 32'h0000_FFFF) : cn[q];
      k = 1 + ($random(seed) & 3);
      dir <= (q == 4);
      ahb(1'b1, OFS_CTRL, 32'h0000_0000);
      ahb(1'b1, OFS_TIMER, n);
      ahb(1'b1, OFS_CTRL, {20'h0_0000, cx[q]} | 32'h0000_0003);
      p = pin_o;
      w = nirq;
      w2 = nwp;
      repeat (6) @(posedge hclk);
      if (cx[q][8]) pulse_nb(k);
      else u_mtc_pin_model.pulse(k);
      repeat (12) @(posedge hclk);
      ahb(1'b0, OFS_TIMER, 32'h0000_0000);
      up = cx[q][9] ? (q == 4) : cx[q][10];
      m = n;
      e = 0;
      for (c = 0; c < k; c++) begin
        if ((up && m == 65535) || (!up && m == 0)) begin
          e++;
          m = cx[q][11] ? (up ? 0 : 65535) : n;
        end else m = up ? m + 1 : m - 1;
      end
      chk(rv, m);
      chk(nirq - w, e);
      chk(nwp - w2, e);
      chk(pin_oe, cx[q][6] & !cx[q][9]);
      if (pin_oe === 1'b1) chk(pin_o, p ^ e[0]);
    end
    test_done;
  end
endmodule : mtc_timer_tb
